// *** src/ptm_pkg.sv ***
// ptm_pkg: register map, field layout, reset values and timing constants of the period timer block
// assumes a 32-bit classic wishbone register bus with one register per aligned word
package ptm_pkg;

	// ********************************************************************
	// register byte offsets
	// ********************************************************************
	localparam logic [7:0] PTM_OFS_COUNT0    = 8'h00;
	localparam logic [7:0] PTM_OFS_PERIOD0   = 8'h04;
	localparam logic [7:0] PTM_OFS_CONTROL0  = 8'h08;
	localparam logic [7:0] PTM_OFS_COUNT1    = 8'h0c;
	localparam logic [7:0] PTM_OFS_PERIOD1   = 8'h10;
	localparam logic [7:0] PTM_OFS_CONTROL1  = 8'h14;
	localparam logic [7:0] PTM_OFS_COUNT2    = 8'h18;
	localparam logic [7:0] PTM_OFS_PERIOD2   = 8'h1c;
	localparam logic [7:0] PTM_OFS_CONTROL2  = 8'h20;
	localparam logic [7:0] PTM_OFS_BASE_SEL  = 8'h24;
	localparam logic [7:0] PTM_OFS_IRQ_FLAGS = 8'h28;
	localparam logic [7:0] PTM_OFS_IRQ_EN    = 8'h2c;
	localparam logic [7:0] PTM_OFS_STEP      = 8'h0c;

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int PTM_CTL_PRE_LSB  = 0;
	localparam int PTM_CTL_ON_BIT   = 2;
	localparam int PTM_CTL_POST_LSB = 3;
	localparam int PTM_CTL_W        = 7;
	localparam int PTM_SEL_CAP0_LSB = 0;
	localparam int PTM_SEL_CAP1_LSB = 2;
	localparam int PTM_SEL_PWM0_LSB = 4;
	localparam int PTM_SEL_PWM1_LSB = 6;

	// ********************************************************************
	// reset values and constants
	// ********************************************************************
	localparam logic [7:0] PTM_RST_COUNT   = 8'h00;
	localparam logic [7:0] PTM_RST_PERIOD  = 8'hff;
	localparam logic [6:0] PTM_RST_CONTROL = 7'h00;
	localparam logic [7:0] PTM_RST_SEL     = 8'h00;
	localparam logic [1:0] PTM_SEL_RSVD    = 2'h3;
	localparam int         PTM_NUM_TIMERS  = 3;
	// instruction clock is the system clock divided by four
	localparam int         PTM_ICLK_DIV    = 4;
	localparam logic [1:0] PTM_ICLK_LAST   = 2'(PTM_ICLK_DIV - 1);

	// prescaler code to terminal count: 0, 3, 15, 63 (divide by 1, 4, 16, 64)
	function automatic logic [5:0] ptm_pre_last(input logic [1:0] code);
		logic [5:0] r;
		r = 6'h00;
		unique case (code)
			2'h0: r = 6'h00;
			2'h1: r = 6'h03;
			2'h2: r = 6'h0f;
			2'h3: r = 6'h3f;
		endcase
		return r;
	endfunction : ptm_pre_last

endpackage : ptm_pkg

// *** src/ptm_timer.sv ***
// ptm_timer: one 8-bit period timer with prescaler, period match and postscaler
// assumes a one-cycle instruction clock tick and same-clock register write strobes
`timescale 1ns/1ps
module ptm_timer
	import ptm_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// timing
	input  wire logic       iclk_tick,
	input  wire logic       sleep,
	// software access
	input  wire logic       count_we,
	input  wire logic       period_we,
	input  wire logic       control_we,
	input  wire logic [7:0] wdata,
	// state
	output logic      [7:0] count_r,
	output logic      [7:0] period_r,
	output logic      [6:0] control_r,
	output logic            match,
	output logic            post_evt
);
	import ptm_pkg::*;

	logic [5:0] pre_r;
	logic [3:0] post_r;
	logic [5:0] pre_nxt;
	logic [3:0] post_nxt;
	logic [7:0] count_nxt;
	logic       running;
	logic       pre_done;
	logic       step;
	logic       scaler_clr;

	// ********************************************************************
	// control decode
	// ********************************************************************
	// sleep freezes prescaler, count and postscaler but not software writes, timer_on gates the count
	assign running    = control_r[PTM_CTL_ON_BIT] && !sleep;
	assign pre_done   = pre_r == ptm_pre_last(control_r[PTM_CTL_PRE_LSB +: 2]);
	assign step       = running && iclk_tick && pre_done;
	// match only on a counting step so a stopped timer raises nothing
	assign match      = step && (count_r == period_r);
	assign scaler_clr = count_we || control_we;
	assign post_evt   = match && (post_r == control_r[PTM_CTL_POST_LSB +: 4]);

	// next-state values; software writes win over counting
	assign pre_nxt   = scaler_clr ? 6'h00 :
		(running && iclk_tick) ? (pre_done ? 6'h00 : pre_r + 6'h01) : pre_r;
	assign post_nxt  = scaler_clr ? 4'h0 :
		post_evt ? 4'h0 : (match ? post_r + 4'h1 : post_r);
	assign count_nxt = count_we ? wdata :
		match ? PTM_RST_COUNT : (step ? count_r + 8'h01 : count_r);

	// ********************************************************************
	// registers
	// ********************************************************************
	// reset clears count and scalers and sets the period to all ones
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_r   <= PTM_RST_COUNT;
			period_r  <= PTM_RST_PERIOD;
			control_r <= PTM_RST_CONTROL;
			pre_r     <= 6'h00;
			post_r    <= 4'h0;
		end
		else
		begin
			count_r   <= count_nxt;
			period_r  <= period_we ? wdata : period_r;
			control_r <= control_we ? wdata[6:0] : control_r;
			pre_r     <= pre_nxt;
			post_r    <= post_nxt;
		end
	end

endmodule : ptm_timer

// *** src/ptm_base_mux.sv ***
// ptm_base_mux: routes one of three timer match pulses to one consumer
// assumes a same-clock select field; the reserved code gives no time base
`timescale 1ns/1ps
module ptm_base_mux
	import ptm_pkg::*;
(
	// selection
	input  wire logic [1:0] sel,
	input  wire logic       gate,
	// time base sources
	input  wire logic [2:0] match,
	// result
	output logic            base
);
	import ptm_pkg::*;

	logic picked;

	// ********************************************************************
	// selection
	// ********************************************************************
	// reserved code picks nothing rather than a guessed timer
	assign picked = (sel == PTM_SEL_RSVD) ? 1'b0 : match[sel];
	assign base   = picked && gate;

endmodule : ptm_base_mux

// *** src/ptm_top.sv ***
// ptm_top: three period timers, shared time base selection and a wishbone register slave
// assumes classic wishbone on clk, a sleep level from the power controller on the same clock,
// and pwm-mode levels from the two capture/compare/pwm units
`timescale 1ns/1ps
module ptm_top
	import ptm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// system state
	input  wire logic        sleep,
	input  wire logic        cap0_pwm_mode,
	input  wire logic        cap1_pwm_mode,
	// time bases
	output logic      [2:0]  serial_shift_clk,
	output logic             cap0_time_base,
	output logic             cap1_time_base,
	output logic             pwm0_time_base,
	output logic             pwm1_time_base,
	// interrupt requests
	output logic      [2:0]  match_irq
);
	import ptm_pkg::*;

	logic [1:0]  iclk_div_r;
	logic        iclk_tick;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic [7:0]  base_sel_r;
	logic [2:0]  irq_flag_r;
	logic [2:0]  irq_en_r;
	logic [2:0]  irq_flag_nxt;
	logic        req;
	logic        wr;
	logic        lane0;
	logic [7:0]  wd;
	logic [7:0]  count_q   [PTM_NUM_TIMERS];
	logic [7:0]  period_q  [PTM_NUM_TIMERS];
	logic [6:0]  control_q [PTM_NUM_TIMERS];
	logic [2:0]  match_v;
	logic [2:0]  post_v;
	logic [2:0]  count_we;
	logic [2:0]  period_we;
	logic [2:0]  control_we;
	logic        sel_we;
	logic        flag_we;
	logic        en_we;
	logic [7:0]  rd_mux;

	// ********************************************************************
	// instruction clock
	// ********************************************************************
	// one tick every fourth system clock; stopped in sleep so no timer advances
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			iclk_div_r <= 2'h0;
		else if (!sleep)
			iclk_div_r <= iclk_div_r + 2'h1;
	end
	assign iclk_tick = (iclk_div_r == PTM_ICLK_LAST) && !sleep;

	// ********************************************************************
	// bus decode
	// ********************************************************************
	// a write only counts on the low lane since every register is one byte wide;
	// it lands on the edge that shows ack to the master, while the request still stands
	assign req   = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign lane0 = wb_sel_i[0];
	assign wd    = wb_dat_i[7:0];

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction : hit

	// per-timer write strobes, register banks spaced by a fixed step
	genvar gi;
	generate
		for (gi = 0; gi < PTM_NUM_TIMERS; gi++)
		begin : g_we
			localparam logic [7:0] STEP = 8'(gi * PTM_OFS_STEP);
			assign count_we[gi]   = wr && lane0 && hit(wb_adr_i, PTM_OFS_COUNT0 + STEP);
			assign period_we[gi]  = wr && lane0 && hit(wb_adr_i, PTM_OFS_PERIOD0 + STEP);
			assign control_we[gi] = wr && lane0 && hit(wb_adr_i, PTM_OFS_CONTROL0 + STEP);
		end
	endgenerate
	assign sel_we  = wr && lane0 && hit(wb_adr_i, PTM_OFS_BASE_SEL);
	assign flag_we = wr && lane0 && hit(wb_adr_i, PTM_OFS_IRQ_FLAGS);
	assign en_we   = wr && lane0 && hit(wb_adr_i, PTM_OFS_IRQ_EN);

	// ********************************************************************
	// timers
	// ********************************************************************
	generate
		for (gi = 0; gi < PTM_NUM_TIMERS; gi++)
		begin : g_tmr
			ptm_timer u_timer (
				.clk        (clk),
				.rst_b      (rst_b),
				.iclk_tick  (iclk_tick),
				.sleep      (sleep),
				.count_we   (count_we[gi]),
				.period_we  (period_we[gi]),
				.control_we (control_we[gi]),
				.wdata      (wd),
				.count_r    (count_q[gi]),
				.period_r   (period_q[gi]),
				.control_r  (control_q[gi]),
				.match      (match_v[gi]),
				.post_evt   (post_v[gi])
			);
		end
	endgenerate

	// unscaled match pulse goes straight to the serial port
	assign serial_shift_clk = match_v;

	// ********************************************************************
	// time base selection
	// ********************************************************************
	ptm_base_mux u_cap0 (
		.sel   (base_sel_r[PTM_SEL_CAP0_LSB +: 2]),
		.gate  (cap0_pwm_mode),
		.match (match_v),
		.base  (cap0_time_base)
	);
	ptm_base_mux u_cap1 (
		.sel   (base_sel_r[PTM_SEL_CAP1_LSB +: 2]),
		.gate  (cap1_pwm_mode),
		.match (match_v),
		.base  (cap1_time_base)
	);
	ptm_base_mux u_pwm0 (
		.sel   (base_sel_r[PTM_SEL_PWM0_LSB +: 2]),
		.gate  (1'b1),
		.match (match_v),
		.base  (pwm0_time_base)
	);
	ptm_base_mux u_pwm1 (
		.sel   (base_sel_r[PTM_SEL_PWM1_LSB +: 2]),
		.gate  (1'b1),
		.match (match_v),
		.base  (pwm1_time_base)
	);

	// ********************************************************************
	// match interrupt flags
	// ********************************************************************
	// software writes 1 to clear; a postscaler event in the same cycle wins
	assign irq_flag_nxt = (irq_flag_r & ~(flag_we ? wd[2:0] : 3'h0)) | post_v;
	assign match_irq    = irq_flag_r & irq_en_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_flag_r <= 3'h0;
			irq_en_r   <= 3'h0;
			base_sel_r <= PTM_RST_SEL;
		end
		else
		begin
			irq_flag_r <= irq_flag_nxt;
			irq_en_r   <= en_we ? wd[2:0] : irq_en_r;
			base_sel_r <= sel_we ? wd : base_sel_r;
		end
	end

	// ********************************************************************
	// read data and acknowledge
	// ********************************************************************
	// unmapped addresses read zero and still get an ack so the master never hangs
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (wb_adr_i)
			PTM_OFS_COUNT0:    rd_mux = count_q[0];
			PTM_OFS_PERIOD0:   rd_mux = period_q[0];
			PTM_OFS_CONTROL0:  rd_mux = {1'b0, control_q[0]};
			PTM_OFS_COUNT1:    rd_mux = count_q[1];
			PTM_OFS_PERIOD1:   rd_mux = period_q[1];
			PTM_OFS_CONTROL1:  rd_mux = {1'b0, control_q[1]};
			PTM_OFS_COUNT2:    rd_mux = count_q[2];
			PTM_OFS_PERIOD2:   rd_mux = period_q[2];
			PTM_OFS_CONTROL2:  rd_mux = {1'b0, control_q[2]};
			PTM_OFS_BASE_SEL:  rd_mux = base_sel_r;
			PTM_OFS_IRQ_FLAGS: rd_mux = {5'h00, irq_flag_r};
			PTM_OFS_IRQ_EN:    rd_mux = {5'h00, irq_en_r};
			default:           rd_mux = 8'h00;
		endcase
	end

	// one wait state: ack the cycle after the request, drop it the next
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r   <= req;
			rdata_r <= req ? {24'h00_0000, rd_mux} : rdata_r;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

endmodule : ptm_top

// *** test/ptm_asserts.sv ***
// ptm_asserts: port-level checks of the period timer block
// assumes it is bound to ptm_top and that the bus master drops stb after each ack
`timescale 1ns/1ps
module ptm_asserts
	import ptm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// system state
	input  wire logic        sleep,
	input  wire logic        cap0_pwm_mode,
	input  wire logic        cap1_pwm_mode,
	// outputs
	input  wire logic [2:0]  serial_shift_clk,
	input  wire logic        cap0_time_base,
	input  wire logic        cap1_time_base,
	input  wire logic        pwm0_time_base,
	input  wire logic        pwm1_time_base,
	input  wire logic [2:0]  match_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// bus answers come exactly one cycle late and last one cycle
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0 ##1 !wb_ack_o)
		else $error("ack longer than one cycle or upper data set");
	ctl_msb_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == PTM_OFS_CONTROL0)
		|-> wb_dat_o[7] == 1'b0)
		else $error("control bit 7 read as one");
	// the fastest timer steps once per instruction clock, never closer than four cycles
	tick_space_a: assert property (serial_shift_clk[0] |=> (!serial_shift_clk[0]) [*3])
		else $error("match pulses closer than four cycles");
	sleep_freeze_a: assert property (sleep && $past(sleep) |-> serial_shift_clk == 3'h0)
		else $error("match pulse during sleep");
	base_src_a: assert property (cap0_time_base || cap1_time_base || pwm0_time_base
		|| pwm1_time_base |-> serial_shift_clk != 3'h0)
		else $error("time base without any timer match");
	cap_gate_a: assert property (!cap0_pwm_mode |-> !cap0_time_base)
		else $error("first capture time base outside pwm mode");
	cap1_gate_a: assert property (!cap1_pwm_mode |-> !cap1_time_base)
		else $error("second capture time base outside pwm mode");
	// a latched flag only drops on a software write
	irq_hold_a: assert property ($fell(match_irq[0]) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
		else $error("interrupt request dropped without a write");
endmodule : ptm_asserts

bind ptm_top ptm_asserts u_asserts (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .sleep, .cap0_pwm_mode, .cap1_pwm_mode, .serial_shift_clk,
	.cap0_time_base, .cap1_time_base, .pwm0_time_base, .pwm1_time_base, .match_irq);

// *** test/ptm_consumer.sv ***
// ptm_consumer: far-side model of the two capture units and two pwm units
// assumes the bench asks for pwm mode and clears the seen flags between checks
`timescale 1ns/1ps
module ptm_consumer
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// bench control
	input  wire logic       pwm_req,
	input  wire logic       clr,
	// mode levels towards the block
	output logic            cap0_pwm_mode,
	output logic            cap1_pwm_mode,
	// time bases from the block and what was seen of them
	input  wire logic [3:0] base,
	output logic      [3:0] seen_r
);
	// both capture units switch mode together; enough to show the gating
	assign cap0_pwm_mode = pwm_req;
	assign cap1_pwm_mode = pwm_req;
	// sticky record of time base pulses, cleared on request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			seen_r <= 4'h0;
		else
			seen_r <= clr ? 4'h0 : (seen_r | base);
	end
endmodule : ptm_consumer

// *** test/ptm_top_tb.sv ***
// ptm_top_tb: self-checking bench of the period timer block over wishbone
// assumes a 20 MHz clock and the consumer model on the time base outputs
`timescale 1ns/1ps
module ptm_top_tb;
	import ptm_pkg::*;
	logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sleep, pwm_req, clr;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        wb_ack_o, cap0_pwm_mode, cap1_pwm_mode;
	logic [2:0]  serial_shift_clk, match_irq;
	wire  [3:0]  base;
	logic [3:0]  seen_r;
	int          mismatches, cmp_count, cycles;

	ptm_top dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep, .cap0_pwm_mode, .cap1_pwm_mode,
		.serial_shift_clk, .cap0_time_base(base[0]), .cap1_time_base(base[1]),
		.pwm0_time_base(base[2]), .pwm1_time_base(base[3]), .match_irq);
	ptm_consumer far (.clk, .rst_b, .pwm_req, .clr, .cap0_pwm_mode, .cap1_pwm_mode, .base,
		.seen_r);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// one classic cycle; entered and left just after a rising edge
	// no wait limit here: only the bench's hang guard ends a stuck cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
	endtask : rdchk
	// cycles between two match pulses of timer t
	task automatic gap(input int t, output int n);
		int k;
		k = 0;
		while (serial_shift_clk[t] !== 1'b1 && k < 2000)
		begin
			@(posedge clk);
			k++;
		end
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (serial_shift_clk[t] !== 1'b1 && n < 2000);
	endtask : gap

	task automatic t_reset();
		rdchk(PTM_OFS_COUNT0, 8'h00);
		rdchk(PTM_OFS_PERIOD2, 8'hff);
		rdchk(PTM_OFS_CONTROL1, 8'h00);
		rdchk(PTM_OFS_BASE_SEL, 8'h00);
		rdchk(8'h30, 8'h00);
	endtask : t_reset
	task automatic t_rw();
		wb(1'b1, PTM_OFS_COUNT0, 8'h55);
		wb(1'b1, PTM_OFS_PERIOD1, 8'ha5);
		wb(1'b1, PTM_OFS_CONTROL0, 8'hff);
		rdchk(PTM_OFS_CONTROL0, 8'h7f);
		wb(1'b1, PTM_OFS_CONTROL0, 8'h00);
		wb(1'b1, PTM_OFS_COUNT0, 8'h55);
		wb(1'b1, PTM_OFS_CONTROL0, 8'h78);
		rdchk(PTM_OFS_COUNT0, 8'h55);
		rdchk(PTM_OFS_PERIOD1, 8'ha5);
		repeat (100) @(posedge clk);
		rdchk(PTM_OFS_COUNT0, 8'h55);
	endtask : t_rw
	// each prescale code: pulse spacing is 4 * divisor * (period + 1)
	task automatic t_pre();
		int n;
		wb(1'b1, PTM_OFS_PERIOD0, 8'h02);
		for (int c = 0; c < 4; c++)
		begin
			wb(1'b1, PTM_OFS_CONTROL0, 8'h04 | 8'(c));
			gap(0, n);
			check(n, 12 << (2 * c));
		end
	endtask : t_pre
	// postscaler ratios; counting starts clean because the count write clears it
	task automatic t_post();
		int n;
		int k;
		logic [3:0] codes [3] = '{4'h0, 4'h2, 4'hf};
		wb(1'b1, PTM_OFS_PERIOD0, 8'h03);
		wb(1'b1, PTM_OFS_IRQ_EN, 8'h01);
		foreach (codes[i])
		begin
			wb(1'b1, PTM_OFS_CONTROL0, 8'h00);
			wb(1'b1, PTM_OFS_COUNT0, 8'h00);
			wb(1'b1, PTM_OFS_IRQ_FLAGS, 8'h01);
			check(match_irq, 3'h0);
			wb(1'b1, PTM_OFS_CONTROL0, {1'b0, codes[i], 3'h4});
			n = 0;
			k = 0;
			while (match_irq[0] !== 1'b1 && k < 600)
			begin
				@(posedge clk);
				k++;
				n += (serial_shift_clk[0] === 1'b1);
			end
			check(n, codes[i] + 1);
		end
		wb(1'b1, PTM_OFS_CONTROL0, 8'h00);
		wb(1'b1, PTM_OFS_IRQ_EN, 8'h00);
		check(match_irq, 3'h0);
		wb(1'b1, PTM_OFS_IRQ_EN, 8'h01);
		check(match_irq, 3'h1);
	endtask : t_post
	task automatic t_sleep();
		wb(1'b1, PTM_OFS_COUNT0, 8'h21);
		sleep <= 1'b1;
		wb(1'b1, PTM_OFS_CONTROL0, 8'h04);
		repeat (60) @(posedge clk);
		rdchk(PTM_OFS_COUNT0, 8'h21);
		sleep <= 1'b0;
		wb(1'b1, PTM_OFS_CONTROL0, 8'h00);
	endtask : t_sleep
	// timers 2 and 3 run, timer 1 is stopped, so codes 01 and 10 alone give pulses
	task automatic t_sel();
		int n;
		wb(1'b1, PTM_OFS_PERIOD1, 8'h01);
		wb(1'b1, PTM_OFS_CONTROL1, 8'h04);
		wb(1'b1, PTM_OFS_PERIOD2, 8'h02);
		wb(1'b1, PTM_OFS_CONTROL2, 8'h04);
		// unscaled match of the second and third timer reaches the serial port
		gap(1, n);
		check(n, 8);
		gap(2, n);
		check(n, 12);
		pwm_req <= 1'b1;
		for (int f = 0; f < 5; f++)
			for (int c = 0; c < 4; c++)
			begin
				if (f == 4)
					pwm_req <= 1'b0;
				wb(1'b1, PTM_OFS_BASE_SEL, 8'(c << (2 * (f % 4))));
				clr <= 1'b1;
				@(posedge clk);
				clr <= 1'b0;
				repeat (30) @(posedge clk);
				// outside pwm mode the first capture unit gets no time base at all
				check(seen_r, (f < 4 && (c == 1 || c == 2)) ? 4'(1 << f) : 4'h0);
			end
	endtask : t_sel

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		{rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sleep, pwm_req, clr} = '0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset();
		t_rw();
		t_pre();
		t_post();
		t_sleep();
		t_sel();
		summarize();
	end
endmodule : ptm_top_tb
